// ### logic/blank_counter.sv
/*
 * Edge blanking counter: after a trigger, active for length clock periods.
 * Assumes trigger is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/1ps
module blank_counter
   import pwm_steer_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   blank_if.cnt      bus
);
   import pwm_steer_pkg::*;

   blank_state_e state_ff;
   byte_t        left_ff;

   // a retrigger restarts the count; zero length gives no blanking
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= BLANK_IDLE;
         left_ff  <= 8'h00;
      end
      else if (bus.trigger && bus.length != 8'h00)
      begin
         state_ff <= BLANK_RUN;
         left_ff  <= bus.length;
      end
      else if (state_ff == BLANK_RUN)
      begin
         left_ff <= left_ff - 8'h01;
         if (left_ff == 8'h01)
            state_ff <= BLANK_IDLE;
      end
   end

   assign bus.active = (state_ff == BLANK_RUN);
endmodule // blank_counter

// ### logic/blank_if.sv
/*
 * Interface carrying one blanking counter's trigger, length and status.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/1ps
interface blank_if;
   logic       trigger;
   logic [7:0] length;
   logic       active;
   modport ctrl (output trigger, output length, input active);
   modport cnt  (input trigger, input length, output active);
endinterface

// ### logic/pwm_blanking_frac_steering.sv
/*
 * Fractional period adjust, rising/falling edge blanking and output
 * steering of a PWM controller, with a simple register port.
 * Assumes period, edge events and the PWM signal come from the counters
 * and mode logic on sys_clk, and that blank_ok qualifies feedback inputs.
 */
`timescale 1ns/1ps
`include "pwm_steer_consts.svh"

module pwm_blanking_frac_steering
   import pwm_steer_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire logic [3:0]          reg_addr,
   input  wire pwm_steer_pkg::byte_t reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output      pwm_steer_pkg::byte_t reg_rdata,
   input  wire pwm_steer_pkg::mode_t output_mode_select,
   input  wire logic                period_match,
   input  wire logic                rise_event,
   input  wire logic                fall_event,
   input  wire logic                pwm_signal,
   output      logic                period_event,
   output      logic                blank_ok,
   output      logic [5:0]          pwm_pins
);
   import pwm_steer_pkg::*;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [3:0] fraction_adjust_field_ff;
   byte_t      rise_blank_count_ff;
   byte_t      fall_blank_count_ff;
   logic [5:0] steer_ff;
   byte_t      rdata_ff;
   logic [4:0] frac_acc_ff;
   logic       hold_ff;
   logic [5:0] pins_ff;

   function automatic logic hit(input logic [3:0] ofs);
      hit = reg_write && (reg_addr == ofs);
   endfunction

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fraction_adjust_field_ff <= `RST_FRACTION_ADJUST;
         rise_blank_count_ff      <= `RST_BLANK;
         fall_blank_count_ff      <= `RST_BLANK;
         steer_ff                 <= `RST_STEERING;
      end
      else
      begin
         if (hit(`OFS_FRACTION_ADJUST))
            fraction_adjust_field_ff <= reg_wdata[`FRAC_MSB:0];
         if (hit(`OFS_RISE_BLANK))
            rise_blank_count_ff <= reg_wdata;
         if (hit(`OFS_FALL_BLANK))
            fall_blank_count_ff <= reg_wdata;
         if (hit(`OFS_STEERING))
            steer_ff <= reg_wdata[`STEER_MSB:0];
      end
   end

   // ----------------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------------
   // unmapped offsets read zero
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_ff <= 8'h00;
      else if (reg_read)
      begin
         unique case (reg_addr)
            `OFS_FRACTION_ADJUST: rdata_ff <= {4'h0, fraction_adjust_field_ff};
            `OFS_RISE_BLANK:      rdata_ff <= rise_blank_count_ff;
            `OFS_FALL_BLANK:      rdata_ff <= fall_blank_count_ff;
            `OFS_STEERING:        rdata_ff <= {2'b00, steer_ff};
            default:              rdata_ff <= 8'h00;
         endcase
      end
      else
         rdata_ff <= 8'h00;
   end
   assign reg_rdata = rdata_ff;

   // ----------------------------------------------------------------------
   // fractional period adjust
   // ----------------------------------------------------------------------
   // sub-clock placement is not possible on one clock, so fractions add
   // up and each carry delays that period event by one whole clock
   // a new fraction starts from the running remainder, not from zero
   logic [4:0] frac_sum;
   assign frac_sum = frac_acc_ff + {1'b0, fraction_adjust_field_ff};

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frac_acc_ff <= 5'h00;
         hold_ff     <= 1'b0;
      end
      else if (period_match)
      begin
         if (frac_sum >= `FRAC_UNITS_PER_CLK)
         begin
            frac_acc_ff <= frac_sum - `FRAC_UNITS_PER_CLK;
            hold_ff     <= 1'b1;
         end
         else
         begin
            frac_acc_ff <= frac_sum;
            hold_ff     <= 1'b0;
         end
      end
      else
         hold_ff <= 1'b0;
   end

   assign period_event = (period_match && frac_sum < `FRAC_UNITS_PER_CLK)
                         || hold_ff;

   // ----------------------------------------------------------------------
   // edge blanking
   // ----------------------------------------------------------------------
   // a retrigger inside a window restarts it, so windows never stack
   blank_if rise_bus ();
   blank_if fall_bus ();

   assign rise_bus.trigger = rise_event;
   assign rise_bus.length  = rise_blank_count_ff;
   assign fall_bus.trigger = fall_event;
   assign fall_bus.length  = fall_blank_count_ff;

   blank_counter u_rise_blank
   (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (rise_bus.cnt)
   );

   blank_counter u_fall_blank
   (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (fall_bus.cnt)
   );

   // feedback stays unqualified while either edge is still ringing
   assign blank_ok = !(rise_bus.active || fall_bus.active);

   // ----------------------------------------------------------------------
   // output steering
   // ----------------------------------------------------------------------
   // pin order is {f,e,d,c,b,a}; inactive drive is low

   // pins lit by one three-phase enable
   function automatic logic [5:0] phase_pair(input logic [2:0] idx);
      unique case (idx)
         3'h0:    phase_pair = 6'h03;
         3'h1:    phase_pair = 6'h05;
         3'h2:    phase_pair = 6'h06;
         3'h3:    phase_pair = 6'h06;
         3'h4:    phase_pair = 6'h12;
         3'h5:    phase_pair = 6'h18;
         default: phase_pair = 6'h00;
      endcase
   endfunction

   logic [5:0] nxt_pins;
   always_comb
   begin
      nxt_pins = 6'h00;
      unique case (output_mode_select)
         `MODE_SINGLE:
            nxt_pins = steer_ff & {6{pwm_signal}};
         `MODE_COMPLEMENTARY:
         begin
            nxt_pins    = steer_ff & {6{pwm_signal}};
            nxt_pins[3] = steer_ff[3] & ~pwm_signal;
            nxt_pins[5] = steer_ff[5] & ~pwm_signal;
         end
         `MODE_THREE_PHASE:
         begin
            // several enables set at once OR their pairs together
            if (pwm_signal)
            begin
               for (int i = 0; i < 6; i++)
               begin
                  if (steer_ff[i])
                     nxt_pins = nxt_pins | phase_pair(3'(i));
               end
            end
         end
         default:
            nxt_pins = 6'h00;
      endcase
   end

   // registered so a mode or steering change cannot glitch a switch
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         pins_ff <= 6'h00;
      else
         pins_ff <= nxt_pins;
   end
   assign pwm_pins = pins_ff;
endmodule // pwm_blanking_frac_steering

// ### logic/pwm_steer_consts.svh
/*
 * Register offsets, field positions, reset values and mode codes for the
 * blanking, fractional adjust and output steering block.
 * Assumes inclusion by bare name from logic/ files.
 */
`ifndef PWM_STEER_CONSTS_SVH
`define PWM_STEER_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_FRACTION_ADJUST   4'h0
`define OFS_RISE_BLANK        4'h1
`define OFS_FALL_BLANK        4'h2
`define OFS_STEERING          4'h3

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define FRAC_MSB              3
`define STEER_MSB             5
`define RST_FRACTION_ADJUST   4'h0
`define RST_BLANK             8'h00
`define RST_STEERING          6'h01
`define FRAC_UNITS_PER_CLK    5'h10

// ----------------------------------------------------------------------
// mode select codes
// ----------------------------------------------------------------------
`define MODE_SINGLE           4'h0
`define MODE_COMPLEMENTARY    4'h1
`define MODE_THREE_PHASE      4'hC

`endif

// ### logic/pwm_steer_pkg.sv
/*
 * Types shared by the steering block and its blanking counter.
 * Assumes nothing of its surroundings.
 */
package pwm_steer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] mode_t;
   typedef enum logic [1:0]
   {
      BLANK_IDLE = 2'b01,
      BLANK_RUN  = 2'b10
   } blank_state_e;
endpackage

// ### test/pwm_steer_asserts.sv
/* Port checker for the steering block.
   Assumes it is bound onto every instance of the top module. */
`timescale 1ns/1ps
module pwm_steer_asserts (
   input wire logic                  sys_clk,
   input wire logic                  reset_n,
   input wire logic [3:0]            reg_addr,
   input wire pwm_steer_pkg::byte_t  reg_wdata,
   input wire logic                  reg_write,
   input wire logic                  reg_read,
   input wire pwm_steer_pkg::byte_t  reg_rdata,
   input wire pwm_steer_pkg::mode_t  output_mode_select,
   input wire logic                  period_match,
   input wire logic                  rise_event,
   input wire logic                  fall_event,
   input wire logic                  pwm_signal,
   input wire logic                  period_event,
   input wire logic                  blank_ok,
   input wire logic [5:0]            pwm_pins
);
   import pwm_steer_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   frac_read_a:
   assert property ((reg_write && reg_addr == 4'h0) ##1 (reg_read && reg_addr == 4'h0)
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0F)) else $error("fraction readback");
   steer_top_a:
   assert property (reg_read && reg_addr == 4'h3 |=> reg_rdata[7:6] == 2'b00)
      else $error("steering top bits");
   quiet_ok_a:
   assert property (blank_ok && !rise_event && !fall_event |=> blank_ok)
      else $error("blanking without edge");
   ev_window_a:
   assert property (period_event |-> period_match || $past(period_match))
      else $error("stray period event");
   carry_next_a:
   assert property (period_match && !period_event |=> period_event)
      else $error("carry event missing");
   single_low_a:
   assert property ($past(output_mode_select) == 4'h0 && !$past(pwm_signal)
      |-> pwm_pins == 6'h00) else $error("single pins active");
   comp_excl_a:
   assert property ($past(output_mode_select) == 4'h1 |-> !(pwm_pins[0] && pwm_pins[3]))
      else $error("complementary overlap");
   tri_pair_a:
   assert property ($past(output_mode_select) == 4'hC && $past(pwm_signal)
      |-> pwm_pins == 6'h00 || $countones(pwm_pins) >= 2) else $error("pin pair broken");
   cover property (period_match && !period_event);
   cover property (rise_event ##1 !blank_ok);
   cover property (fall_event ##1 !blank_ok);
endmodule // pwm_steer_asserts
bind pwm_blanking_frac_steering pwm_steer_asserts pwm_steer_asserts_i (.*);

// ### test/switch_drivers.sv
/* Model of the gate drivers that hang on the six PWM pins.
   Assumes the pins are sampled on sys_clk. */
`timescale 1ns/1ps
module switch_drivers (
   input  wire logic       sys_clk,
   input  wire logic [5:0] pwm_pins,
   output      logic [5:0] gate_ff
);
   // level shifters add one clock of delay before the switches move
   always_ff @(posedge sys_clk)
      gate_ff <= pwm_pins;
endmodule // switch_drivers

// ### test/tb_top.sv
/* Self-checking bench for the steering block.
   Assumes the checker binds itself onto the design. */
`timescale 1ns/1ps
`include "pwm_steer_consts.svh"
module tb_top;
   import pwm_steer_pkg::*;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   byte_t      reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   byte_t      reg_rdata;
   mode_t      mode = 4'h0;
   logic       period_match = 1'b0;
   logic       rise_event = 1'b0;
   logic       fall_event = 1'b0;
   logic       pwm_signal = 1'b0;
   logic       period_event;
   logic       blank_ok;
   logic [5:0] pwm_pins;
   logic [5:0] gate;
   int         error_cnt = 0;
   int         comparisons = 0;
   int         acc;
   int         n;
   byte_t      rd;
   logic [3:0] field;
   mode_t      modes [4] = '{4'h0, 4'h1, 4'hC, 4'h6};
   byte_t      lens [5] = '{8'h00, 8'h01, 8'h02, 8'hFF, 8'h07};
   always #2 sys_clk = ~sys_clk;
   pwm_blanking_frac_steering pwm_blanking_frac_steering_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .output_mode_select(mode), .period_match(period_match), .rise_event(rise_event),
      .fall_event(fall_event), .pwm_signal(pwm_signal), .period_event(period_event),
      .blank_ok(blank_ok), .pwm_pins(pwm_pins));
   switch_drivers switch_drivers_i (.sys_clk(sys_clk), .pwm_pins(pwm_pins), .gate_ff(gate));
   task automatic chk(string what, byte_t seen, byte_t exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // the write strobe is lowered by whoever drives next, so writes can run back to back
   task automatic wr(logic [3:0] a, byte_t d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
   endtask
   task automatic rdc(string what, logic [3:0] a, byte_t exp);
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(what, reg_rdata, exp);
   endtask
   function automatic byte_t exp_pins(mode_t m, byte_t s, logic p);
      byte_t pair [6] = '{8'h03, 8'h05, 8'h06, 8'h06, 8'h12, 8'h18};
      byte_t r = 8'h00;
      if (m == `MODE_SINGLE)
         r = s & {2'b00, {6{p}}};
      if (m == `MODE_COMPLEMENTARY)
         r = s & {2'b00, ~p, p, ~p, p, p, p};
      if (m == `MODE_THREE_PHASE && p)
         for (int i = 0; i < 6; i++)
            if (s[i])
               r |= pair[i];
      return r;
   endfunction
   task automatic blank(logic sel, byte_t len);
      wr(sel ? `OFS_FALL_BLANK : `OFS_RISE_BLANK, len);
      @(posedge sys_clk);
      reg_write <= 1'b0;
      rise_event <= !sel;
      fall_event <= sel;
      @(posedge sys_clk);
      rise_event <= 1'b0;
      fall_event <= 1'b0;
      #1 n = 0;
      while (blank_ok !== 1'b1 && n < 300)
      begin
         n++;
         @(posedge sys_clk);
         #1;
      end
      chk("blank length", n[7:0], len);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #80000;
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(32'h1A509163));
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      rdc("fraction reset", `OFS_FRACTION_ADJUST, 8'h00);
      rdc("rise reset", `OFS_RISE_BLANK, 8'h00);
      rdc("fall reset", `OFS_FALL_BLANK, 8'h00);
      rdc("steering reset", `OFS_STEERING, 8'h01);
      wr(4'h9, 8'hFF);
      rdc("unmapped", 4'h9, 8'h00);
      rdc("rise after unmapped", `OFS_RISE_BLANK, 8'h00);
      repeat (4)
      begin
         rd = 8'($urandom);
         wr(`OFS_FRACTION_ADJUST, rd);
         rdc("fraction", `OFS_FRACTION_ADJUST, rd & 8'h0F);
         wr(`OFS_STEERING, rd);
         rdc("steering", `OFS_STEERING, rd & 8'h3F);
      end
      $display("registers done");
      for (int i = 0; i < 48; i++)
      begin
         rd = 8'($urandom);
         wr(`OFS_STEERING, rd);
         @(posedge sys_clk);
         reg_write <= 1'b0;
         mode <= modes[i % 4];
         pwm_signal <= 1'($urandom);
         @(posedge sys_clk);
         #1 chk("pins", {2'b00, pwm_pins}, exp_pins(mode, rd & 8'h3F, pwm_signal));
         @(posedge sys_clk);
         #1 chk("gate", {2'b00, gate}, exp_pins(mode, rd & 8'h3F, pwm_signal));
      end
      // corner: pin D enable alone in three-phase lights pins B and C
      wr(`OFS_STEERING, 8'h08);
      @(posedge sys_clk);
      reg_write <= 1'b0;
      mode <= `MODE_THREE_PHASE;
      pwm_signal <= 1'b1;
      @(posedge sys_clk);
      #1 chk("pins d pair", {2'b00, pwm_pins}, 8'h06);
      $display("steering done");
      lens[4] = 8'($urandom_range(3, 40));
      foreach (lens[i])
      begin
         blank(1'b0, lens[i]);
         blank(1'b1, lens[i]);
      end
      $display("blanking done");
      field = 4'($urandom_range(1, 15));
      wr(`OFS_FRACTION_ADJUST, {4'h0, field});
      acc = 0;
      // carry into a whole clock delays the event by exactly one cycle
      repeat (20)
      begin
         @(posedge sys_clk);
         reg_write <= 1'b0;
         period_match <= 1'b1;
         #1 rd[1] = period_event;
         @(posedge sys_clk);
         period_match <= 1'b0;
         #1 rd[0] = period_event;
         acc += field;
         chk("period event", {6'h00, rd[1:0]}, acc >= 16 ? 8'h01 : 8'h02);
         acc = acc % 16;
         @(posedge sys_clk);
      end
      $display("period done");
      // second reset in mid-run, with every register holding a non-reset value
      wr(`OFS_RISE_BLANK, 8'hA5);
      wr(`OFS_FALL_BLANK, 8'h5A);
      wr(`OFS_STEERING, 8'h3E);
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reset_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      rdc("fraction reset again", `OFS_FRACTION_ADJUST, 8'h00);
      rdc("rise reset again", `OFS_RISE_BLANK, 8'h00);
      rdc("fall reset again", `OFS_FALL_BLANK, 8'h00);
      rdc("steering reset again", `OFS_STEERING, 8'h01);
      $display("reset done");
      wrap_up();
   end
endmodule // tb_top
